//--- hw/dnh_map.vh
// Register map, field positions, reset values and latencies of the mixer.
`ifndef DNH_MAP_VH
`define DNH_MAP_VH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DNH_OFF_CTRL 8'h00
`define DNH_OFF_STATUS 8'h04
`define DNH_OFF_RDIV 8'h08
`define DNH_OFF_FREQ_BASE 8'h20
`define DNH_OFF_PHASE_BASE 8'h40
// ****************************************************************
// Control fields and reset values
// ****************************************************************
`define DNH_CTRL_DUAL 0
`define DNH_CTRL_DDC_EN 1
`define DNH_CTRL_SRC 2
`define DNH_CTRL_SELA_LO 3
`define DNH_CTRL_SELB_LO 5
`define DNH_CTRL_ROUTE_B 7
`define DNH_CTRL_RESET 8'h01
`define DNH_RDIV_RESET 16'h0000
`define DNH_FREQ_RESET 32'h00000000
`define DNH_PHASE_RESET 16'h0000
// ****************************************************************
// Latencies in sample-clock cycles and FIFO depth in entries
// ****************************************************************
`define DNH_SAMPLE_LAT 36
`define DNH_HOP_SYNC 2
`define DNH_HOP_PIPE 34
`define DNH_FIFO_DEPTH 16
`endif

//--- hw/dnh_fifo.v
// Synchronous FIFO with registered ready and valid flags.
`timescale 1ns/1ns
module dnh_fifo #(
    parameter WIDTH = 64,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire rst_n,
    input wire inValid,
    input wire [WIDTH-1:0] inData,
    output reg inReady,
    output reg outValid,
    output wire [WIDTH-1:0] outData,
    input wire outReady
);
    localparam [AW:0] FULL = DEPTH;
    localparam [AW:0] ONE = 1;
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr;
    reg [AW-1:0] rdPtr;
    reg [AW:0] count;
    reg [AW:0] next_count;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;

    // Flags are computed from the next count so both stay flip-flops.
    always @* begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + ONE;
        end else if (pop && !push) begin
            next_count = count - ONE;
        end
    end

    // Storage has no reset; only pointers and flags need a known value.
    always @(posedge clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    // Pointer and flag update.
    always @(posedge clk) begin
        if (!rst_n) begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            inReady <= 1'b0;
            outValid <= 1'b0;
        end else begin
            if (push) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= rdPtr + 1'b1;
            end
            count <= next_count;
            inReady <= (next_count != FULL);
            outValid <= (next_count != {(AW+1){1'b0}});
        end
    end

    assign outData = mem[rdPtr];
endmodule

//--- hw/dnh_mixer_top.v
// Eight-oscillator hopping NCO bank (four per channel) and complex mixer for two channels.
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
`include "dnh_map.vh"
module dnh_mixer_top (
    input wire clk,
    input wire rst_n,
    input wire [7:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsWriteData,
    input wire [3:0] avsByteEnable,
    output reg [31:0] avsReadData,
    output reg avsWaitRequest,
    input wire sampleValid,
    input wire [11:0] sampleA,
    input wire [11:0] sampleB,
    output wire sampleReady,
    input wire [1:0] chanAHopPins,
    input wire [1:0] chanBHopPins,
    output reg outValid,
    output reg outMixed,
    output reg [15:0] outAI,
    output reg [15:0] outAQ,
    output reg [15:0] outBI,
    output reg [15:0] outBQ,
    input wire outReady
);
    // ****************************************************************
    // Functions
    // ****************************************************************
    // Byte-lane merge used by every writable register.
    function [31:0] mergeBe;
        input [31:0] old;
        input [31:0] wdata;
        input [3:0] be;
        integer k;
        begin
            mergeBe = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    mergeBe[8*k +: 8] = wdata[8*k +: 8];
                end
            end
        end
    endfunction

    // True when addr is one of the eight words of a bank.
    function inBank;
        input [7:0] addr;
        input [7:0] base;
        begin
            inBank = (addr[7:5] == base[7:5]) && (addr[1:0] == 2'b00);
        end
    endfunction

    // Sine of a 6-bit phase; a 16-entry quarter table keeps it small.
    function signed [11:0] sine;
        input [5:0] ph;
        reg [3:0] k;
        reg [11:0] mag;
        begin
            k = ph[4] ? ~ph[3:0] : ph[3:0];
            case (k)
                4'h0: mag = 12'h000;
                4'h1: mag = 12'h0c9;
                4'h2: mag = 12'h18f;
                4'h3: mag = 12'h252;
                4'h4: mag = 12'h30f;
                4'h5: mag = 12'h3c5;
                4'h6: mag = 12'h471;
                4'h7: mag = 12'h513;
                4'h8: mag = 12'h5a7;
                4'h9: mag = 12'h62e;
                4'ha: mag = 12'h6a6;
                4'hb: mag = 12'h70d;
                4'hc: mag = 12'h763;
                4'hd: mag = 12'h7a7;
                4'he: mag = 12'h7d8;
                default: mag = 12'h7f5;
            endcase
            sine = ph[5] ? -$signed(mag) : $signed(mag);
        end
    endfunction

    // Mix one sample with one oscillator phase into 16-bit I or Q.
    function [15:0] mixPart;
        input [11:0] smp;
        input [5:0] ph;
        reg signed [23:0] prod;
        begin
            prod = $signed(smp) * sine(ph);
            mixPart = prod[22:7];
        end
    endfunction

    // ****************************************************************
    // Register file
    // ****************************************************************
    reg [7:0] ctrl;
    reg [15:0] rationalStepDivisor;
    reg [31:0] freqWord [0:7];
    reg [15:0] phaseOffset [0:7];
    reg [1:0] activeIdxA;
    reg [1:0] activeIdxB;
    integer i;
    integer j;
    integer m;

    wire dualMode = ctrl[`DNH_CTRL_DUAL];
    wire ddcEnable = ctrl[`DNH_CTRL_DDC_EN];
    wire oscSelectSource = ctrl[`DNH_CTRL_SRC];
    wire [1:0] chanASoftSelect = ctrl[`DNH_CTRL_SELA_LO +: 2];
    wire [1:0] chanBSoftSelect = ctrl[`DNH_CTRL_SELB_LO +: 2];
    wire chanBInputRoute = ctrl[`DNH_CTRL_ROUTE_B];
    wire ddcActive = dualMode && ddcEnable;
    wire wrTake = avsWrite && !avsWaitRequest;
    wire [31:0] freqRd = freqWord[avsAddress[4:2]];
    wire [15:0] phaseRd = phaseOffset[avsAddress[4:2]];
    // Merged words are cut to each register's width on purpose.
    wire [31:0] ctrlMerged = mergeBe({24'h000000, ctrl}, avsWriteData,
        avsByteEnable);
    wire [31:0] rdivMerged = mergeBe({16'h0000, rationalStepDivisor},
        avsWriteData, avsByteEnable);
    wire [31:0] phaseMerged = mergeBe({16'h0000, phaseRd}, avsWriteData,
        avsByteEnable);

    // Wait one cycle per access; the write lands at the released edge.
    always @(posedge clk) begin
        if (!rst_n) begin
            avsWaitRequest <= 1'b1;
            avsReadData <= 32'h00000000;
        end else if ((avsRead || avsWrite) && avsWaitRequest) begin
            avsWaitRequest <= 1'b0;
            avsReadData <= 32'h00000000;
            if (avsRead) begin
                if (avsAddress == `DNH_OFF_CTRL) begin
                    avsReadData <= {24'h000000, ctrl};
                end else if (avsAddress == `DNH_OFF_STATUS) begin
                    avsReadData <= {26'h0000000, sampleReady, ddcActive,
                        activeIdxB, activeIdxA};
                end else if (avsAddress == `DNH_OFF_RDIV) begin
                    avsReadData <= {16'h0000, rationalStepDivisor};
                end else if (inBank(avsAddress, `DNH_OFF_FREQ_BASE)) begin
                    avsReadData <= freqRd;
                end else if (inBank(avsAddress, `DNH_OFF_PHASE_BASE)) begin
                    avsReadData <= {16'h0000, phaseRd};
                end
            end
        end else begin
            avsWaitRequest <= 1'b1;
        end
    end

    // Register writes; unmapped addresses are ignored.
    always @(posedge clk) begin
        if (!rst_n) begin
            ctrl <= `DNH_CTRL_RESET;
            rationalStepDivisor <= `DNH_RDIV_RESET;
            for (i = 0; i < 8; i = i + 1) begin
                freqWord[i] <= `DNH_FREQ_RESET;
                phaseOffset[i] <= `DNH_PHASE_RESET;
            end
        end else if (wrTake) begin
            if (avsAddress == `DNH_OFF_CTRL) begin
                ctrl <= ctrlMerged[7:0];
            end else if (avsAddress == `DNH_OFF_RDIV) begin
                rationalStepDivisor <= rdivMerged[15:0];
            end else if (inBank(avsAddress, `DNH_OFF_FREQ_BASE)) begin
                freqWord[avsAddress[4:2]] <= mergeBe(freqRd,
                    avsWriteData, avsByteEnable);
            end else if (inBank(avsAddress, `DNH_OFF_PHASE_BASE)) begin
                phaseOffset[avsAddress[4:2]] <= phaseMerged[15:0];
            end
        end
    end

    // ****************************************************************
    // Oscillator bank
    // ****************************************************************
    reg [31:0] acc [0:7];

    // All eight accumulators advance every sample clock, selected or not.
    always @(posedge clk) begin
        if (!rst_n) begin
            for (j = 0; j < 8; j = j + 1) begin
                acc[j] <= 32'h00000000;
            end
        end else begin
            for (j = 0; j < 8; j = j + 1) begin
                acc[j] <= acc[j] + freqWord[j];
            end
        end
    end

    // ****************************************************************
    // Hop-pin synchroniser and latency pipe
    // ****************************************************************
    reg [3:0] hopMeta;
    reg [3:0] hopSync;
    reg [4*`DNH_HOP_PIPE-1:0] hopPipe;
    wire [1:0] hopA = hopPipe[4*`DNH_HOP_PIPE-4 +: 2];
    wire [1:0] hopB = hopPipe[4*`DNH_HOP_PIPE-1 -: 2];

    // The pins change at any time, so only the second stage is used.
    always @(posedge clk) begin
        if (!rst_n) begin
            hopMeta <= 4'h0;
            hopSync <= 4'h0;
            hopPipe <= {(4*`DNH_HOP_PIPE){1'b0}};
        end else begin
            hopMeta <= {chanBHopPins, chanAHopPins};
            hopSync <= hopMeta;
            hopPipe <= {hopPipe[4*`DNH_HOP_PIPE-5:0], hopSync};
        end
    end

    // Source selection; a changed pin value is a hop by itself.
    always @(posedge clk) begin
        if (!rst_n) begin
            activeIdxA <= 2'b00;
            activeIdxB <= 2'b00;
        end else if (oscSelectSource) begin
            activeIdxA <= hopA;
            activeIdxB <= hopB;
        end else begin
            activeIdxA <= chanASoftSelect;
            activeIdxB <= chanBSoftSelect;
        end
    end

    // ****************************************************************
    // Sample delay line and mixer
    // ****************************************************************
    wire advance = sampleReady;
    reg [11:0] dlyA [0:`DNH_SAMPLE_LAT-1];
    reg [11:0] dlyB [0:`DNH_SAMPLE_LAT-1];
    reg [`DNH_SAMPLE_LAT-1:0] dlyValid;
    reg mixValid;
    reg mixedTag;
    reg [63:0] mixWord;
    wire [31:0] phA = acc[{1'b0, activeIdxA}]
        + {phaseOffset[{1'b0, activeIdxA}], 16'h0000};
    wire [31:0] phB = acc[{1'b1, activeIdxB}]
        + {phaseOffset[{1'b1, activeIdxB}], 16'h0000};
    wire [11:0] mixA = dlyA[`DNH_SAMPLE_LAT-1];
    wire [11:0] mixB = dlyB[`DNH_SAMPLE_LAT-1];

    // The line stalls with the FIFO; oscillators keep running meanwhile.
    always @(posedge clk) begin
        if (!rst_n) begin
            dlyValid <= {`DNH_SAMPLE_LAT{1'b0}};
        end else if (advance) begin
            dlyValid <= {dlyValid[`DNH_SAMPLE_LAT-2:0], sampleValid};
        end
    end

    // Data shift; channel B input is picked by its route bit.
    always @(posedge clk) begin
        if (advance) begin
            dlyA[0] <= sampleA;
            dlyB[0] <= chanBInputRoute ? sampleA : sampleB;
            for (m = 1; m < `DNH_SAMPLE_LAT; m = m + 1) begin
                dlyA[m] <= dlyA[m-1];
                dlyB[m] <= dlyB[m-1];
            end
        end
    end

    // Mix with cos and -sin of the phase, or pass the sample through.
    always @(posedge clk) begin
        if (!rst_n) begin
            mixValid <= 1'b0;
            mixedTag <= 1'b0;
            mixWord <= 64'h0000000000000000;
        end else if (advance) begin
            mixValid <= dlyValid[`DNH_SAMPLE_LAT-1];
            mixedTag <= ddcActive;
            if (ddcActive) begin
                mixWord <= {mixPart(mixB, phB[31:26] + 6'h10),
                    mixPart(mixB, phB[31:26] + 6'h20),
                    mixPart(mixA, phA[31:26] + 6'h10),
                    mixPart(mixA, phA[31:26] + 6'h20)};
            end else begin
                mixWord <= {mixB, 4'h0, 16'h0000,
                    mixA, 4'h0, 16'h0000};
            end
        end
    end

    // ****************************************************************
    // Output buffer and registered stream port
    // ****************************************************************
    wire fifoOutValid;
    wire [64:0] fifoOutData;
    wire fifoPop = !outValid || outReady;

    // The mode tag rides with its word, so a mode change never mislabels
    // words that are already queued.
    dnh_fifo #(
        .WIDTH(65),
        .DEPTH(`DNH_FIFO_DEPTH),
        .AW(4)
    ) u_dnh_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .inValid(mixValid && advance),
        .inData({mixedTag, mixWord}),
        .inReady(sampleReady),
        .outValid(fifoOutValid),
        .outData(fifoOutData),
        .outReady(fifoPop)
    );

    // Output register loads whenever it is empty or being taken.
    always @(posedge clk) begin
        if (!rst_n) begin
            outValid <= 1'b0;
            outMixed <= 1'b0;
            outAI <= 16'h0000;
            outAQ <= 16'h0000;
            outBI <= 16'h0000;
            outBQ <= 16'h0000;
        end else if (fifoPop) begin
            outValid <= fifoOutValid;
            if (fifoOutValid) begin
                outMixed <= fifoOutData[64];
                outAQ <= fifoOutData[15:0];
                outAI <= fifoOutData[31:16];
                outBQ <= fifoOutData[47:32];
                outBI <= fifoOutData[63:48];
            end
        end
    end
endmodule

//--- bench/dnh_far_model.sv
// Far-side model: converter sample source and output consumer.
`timescale 1ns/1ns
module dnh_far_model (
    input wire clk,
    input wire rst_n,
    input wire sendReq,
    input wire [5:0] sendNum,
    input wire [11:0] sendA,
    input wire [11:0] sendB,
    input wire sinkStall,
    input wire sampleReady,
    output reg sampleValid,
    output reg [11:0] sampleA,
    output reg [11:0] sampleB,
    output reg outReady
);
    reg [5:0] left;
    // A burst of counting samples is held until taken; idle data is
    // inverted so a stale word can never pass for a fresh one.
    always @(posedge clk) begin
        if (!rst_n) begin
            left <= 6'h00;
            sampleValid <= 1'b0;
            sampleA <= 12'h000;
            sampleB <= 12'h000;
            outReady <= 1'b0;
        end else begin
            outReady <= !sinkStall;
            if (sendReq) begin
                left <= sendNum;
                sampleValid <= 1'b1;
                sampleA <= sendA;
                sampleB <= sendB;
            end else if (sampleValid && sampleReady) begin
                left <= left - 6'h01;
                if (left == 6'h01) begin
                    sampleValid <= 1'b0;
                    sampleA <= ~sampleA;
                    sampleB <= ~sampleB;
                end else begin
                    sampleA <= sampleA + 12'h001;
                    sampleB <= sampleB + 12'h001;
                end
            end
        end
    end
endmodule

//--- bench/dnh_mixer_checker.sv
// Concurrent checks on the mixer's bus, stream and reset behaviour.
`timescale 1ns/1ns
module dnh_mixer_checker (
    input wire clk,
    input wire rst_n,
    input wire [7:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsReadData,
    input wire avsWaitRequest,
    input wire sampleReady,
    input wire outValid,
    input wire outMixed,
    input wire [15:0] outAI,
    input wire [15:0] outAQ,
    input wire [15:0] outBI,
    input wire [15:0] outBQ,
    input wire outReady
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ********
    // Bus handshake
    // ********
    wait_pulse_a:
        assert property (!avsWaitRequest |=> avsWaitRequest)
        else $error("waitrequest low for more than one cycle");
    bus_answer_a:
        assert property ((avsRead || avsWrite) && avsWaitRequest
            |=> !avsWaitRequest)
        else $error("bus request not answered in one cycle");
    bus_idle_a:
        assert property (!(avsRead || avsWrite) && avsWaitRequest
            |=> avsWaitRequest)
        else $error("waitrequest dropped without a request");
    unmapped_zero_a:
        assert property (avsRead && !avsWaitRequest
            && avsAddress[7:5] == 3'b111 |-> avsReadData == 32'h0)
        else $error("unmapped read returned nonzero data");
    // ********
    // Stream and reset
    // ********
    out_hold_a:
        assert property (outValid && !outReady |=> outValid
            && $stable(outAI) && $stable(outAQ) && $stable(outBI)
            && $stable(outBQ) && $stable(outMixed))
        else $error("output word changed while stalled");
    bypass_quad_a:
        assert property (outValid && !outMixed |-> outAQ == 16'h0000
            && outBQ == 16'h0000)
        else $error("bypass word has nonzero quadrature");
    bypass_scale_a:
        assert property (outValid && !outMixed |-> outAI[3:0] == 4'h0
            && outBI[3:0] == 4'h0)
        else $error("bypass word not a shifted sample");
    full_refuse_a:
        assert property ($past(rst_n) && !sampleReady |-> outValid)
        else $error("input refused while buffer not full");
    reset_clear_a:
        assert property (rst_n && !$past(rst_n) |-> !outValid
            && avsWaitRequest && !sampleReady)
        else $error("outputs not cleared by reset");
endmodule
bind dnh_mixer_top dnh_mixer_checker u_dnh_mixer_checker (.*);

//--- bench/test_dnh_mixer_top.sv
// Self-checking bench for the hopping oscillator mixer.
`timescale 1ns/1ns
module test_dnh_mixer_top;
    reg clk = 1'b0, rst_n = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
    reg [7:0] avsAddress = 8'h00;
    reg [31:0] avsWriteData = 32'h0;
    reg [3:0] avsByteEnable = 4'hf;
    reg [1:0] chanAHopPins = 2'b00, chanBHopPins = 2'b00;
    reg sendReq = 1'b0, sinkStall = 1'b0;
    reg [5:0] sendNum = 6'h01;
    reg [11:0] sendA = 12'h000, sendB = 12'h000;
    wire [31:0] avsReadData;
    wire [15:0] outAI, outAQ, outBI, outBQ;
    wire [11:0] sampleA, sampleB;
    wire avsWaitRequest, sampleValid, sampleReady, outValid, outMixed;
    wire outReady;
    reg [31:0] rd;
    integer fails = 0, num_checks = 0, cyc = 0, i;
    dnh_mixer_top u_dnh_mixer_top (.clk(clk), .rst_n(rst_n),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .sampleValid(sampleValid), .sampleA(sampleA), .sampleB(sampleB),
        .sampleReady(sampleReady), .chanAHopPins(chanAHopPins),
        .chanBHopPins(chanBHopPins), .outValid(outValid),
        .outMixed(outMixed), .outAI(outAI), .outAQ(outAQ), .outBI(outBI),
        .outBQ(outBQ), .outReady(outReady));
    dnh_far_model u_dnh_far_model (.clk(clk), .rst_n(rst_n),
        .sendReq(sendReq), .sendNum(sendNum), .sendA(sendA),
        .sendB(sendB), .sinkStall(sinkStall), .sampleReady(sampleReady),
        .sampleValid(sampleValid), .sampleA(sampleA), .sampleB(sampleB),
        .outReady(outReady));
    // Free-running clock and a hang guard sized well above the tests.
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            results;
        end
    end
    task results;
        begin
            $display("checks %0d mismatches %0d", num_checks, fails);
            if (fails == 0 && num_checks > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    task check(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("ERROR t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // One bus access, held until waitrequest is seen low at an edge.
    task bus(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            n = 0;
            @(posedge clk);
            avsRead <= !w;
            avsWrite <= w;
            avsAddress <= a;
            avsWriteData <= d;
            @(posedge clk);
            while (avsWaitRequest !== 1'b0 && n < 50) begin
                n = n + 1;
                @(posedge clk);
            end
            if (n == 50) check(32'h1, 32'h0);
            rd = avsReadData;
            avsRead <= 1'b0;
            avsWrite <= 1'b0;
        end
    endtask
    task send(input [5:0] num, input [11:0] a, input [11:0] b);
        begin
            @(posedge clk);
            sendNum <= num;
            sendA <= a;
            sendB <= b;
            sendReq <= 1'b1;
            @(posedge clk);
            sendReq <= 1'b0;
        end
    endtask
    // Waits for a popped word; the caller then reads the output ports.
    task pop;
        integer n;
        begin
            n = 0;
            @(posedge clk);
            while (!(outValid === 1'b1 && outReady === 1'b1) && n < 300) begin
                n = n + 1;
                @(posedge clk);
            end
            if (n == 300) check(32'h1, 32'h0);
        end
    endtask
    // One sample in; aw is {I, Q} of channel A and bw that of channel B.
    task one(input [11:0] a, input [11:0] b, input [31:0] aw,
        input [31:0] bw, input mixed);
        begin
            send(6'h01, a, b);
            pop;
            check({outAI, outAQ}, aw);
            check({outBI, outBQ}, bw);
            check({31'h0, outMixed}, {31'h0, mixed});
        end
    endtask
    task t_regs;
        begin
            bus(1'b0, 8'h00, 32'h0);
            check(rd, 32'h1);
            bus(1'b1, 8'hfc, 32'hffffffff);
            bus(1'b0, 8'hfc, 32'h0);
            check(rd, 32'h0);
            bus(1'b1, 8'h08, 32'hffff1234);
            bus(1'b0, 8'h08, 32'h0);
            check(rd, 32'h1234);
            bus(1'b1, 8'h24, 32'h89abcdef);
            bus(1'b0, 8'h24, 32'h0);
            check(rd, 32'h89abcdef);
            bus(1'b0, 8'h38, 32'h0);
            check(rd, 32'h0);
            $display("regs test done");
        end
    endtask
    task t_bypass;
        begin
            one(12'h123, 12'h456, 32'h12300000, 32'h45600000, 1'b0);
            bus(1'b1, 8'h00, 32'h02);
            one(12'h321, 12'h654, 32'h32100000, 32'h65400000, 1'b0);
            bus(1'b1, 8'h00, 32'h81);
            one(12'h0ab, 12'h777, 32'h0ab00000, 32'h0ab00000, 1'b0);
            $display("bypass test done");
        end
    endtask
    // Zero frequency keeps every accumulator but oscillator 1 at zero phase, so only the
    // offsets of the selected oscillators move the result.
    task t_mix;
        begin
            bus(1'b1, 8'h00, 32'h03);
            one(12'h100, 12'h100, 32'h0fea0000, 32'h0fea0000, 1'b1);
            bus(1'b1, 8'h48, 32'h8000);
            bus(1'b1, 8'h5c, 32'h8000);
            one(12'h100, 12'h100, 32'h0fea0000, 32'h0fea0000, 1'b1);
            bus(1'b1, 8'h00, 32'h73);
            one(12'h100, 12'h100, 32'hf0160000, 32'hf0160000, 1'b1);
            // Quarter turns on A and three quarters on B put the whole
            // product into Q, with opposite signs on the two channels.
            bus(1'b1, 8'h00, 32'h03);
            bus(1'b1, 8'h40, 32'h4000);
            bus(1'b1, 8'h50, 32'hc000);
            one(12'h100, 12'h100, 32'h0000f016, 32'h00000fea, 1'b1);
            $display("mix test done");
        end
    endtask
    task t_hop;
        begin
            bus(1'b1, 8'h00, 32'h07);
            @(posedge clk);
            chanAHopPins <= 2'b10;
            chanBHopPins <= 2'b01;
            repeat (28) @(posedge clk);
            bus(1'b0, 8'h04, 32'h0);
            check({28'h0, rd[3:0]}, 32'h0);
            repeat (10) @(posedge clk);
            bus(1'b0, 8'h04, 32'h0);
            check({28'h0, rd[3:0]}, 32'h6);
            bus(1'b1, 8'h00, 32'h6b);
            bus(1'b0, 8'h04, 32'h0);
            check({28'h0, rd[3:0]}, 32'hd);
            $display("hop test done");
        end
    endtask
    task t_fill;
        begin
            bus(1'b1, 8'h00, 32'h01);
            @(posedge clk);
            sinkStall <= 1'b1;
            send(6'h18, 12'h100, 12'h200);
            repeat (80) @(posedge clk);
            check({31'h0, sampleReady}, 32'h0);
            sinkStall <= 1'b0;
            for (i = 0; i < 24; i = i + 1) begin
                pop;
                check({outAI, outBI}, {12'h100 + i[11:0], 4'h0,
                    12'h200 + i[11:0], 4'h0});
            end
            repeat (4) @(posedge clk);
            check({31'h0, outValid}, 32'h0);
            $display("fill test done");
        end
    endtask
    // Reset for four cycles, then the scenarios in turn.
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_bypass;
        t_mix;
        t_hop;
        t_fill;
        results;
    end
endmodule
